// *** design/qzs_top.sv ***
// Gating, conversion sequencing, sliding-scale removal, zero and overflow
// suppression, threshold memory and output FIFO of the charge digitiser.
// Assumes converters that answer a start pulse with a one-cycle done pulse,
// and a downstream event buffer that drains the FIFO by valid/ready.
`timescale 1ns/10ps

module qzs_fifo
  import qzs_pkg::*;
#(
  parameter int WIDTH = 21,
  parameter int DEPTH = 16
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("qzs_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;

  wire logic doPush = inValid && inReady;
  wire logic doPop = outValid && outReady;

  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  assign count_nxt = count_r + (AW+1)'(doPush) - (AW+1)'(doPop);

  // Storage has no reset; only the pointers and the count must be defined
  always_ff @(posedge clk_sys)
  begin
    if (doPush)
      mem[wrPtr_r] <= inData;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_r + AW'(doPush);
      rdPtr_r <= rdPtr_r + AW'(doPop);
      count_r <= count_nxt;
    end
  end

endmodule : qzs_fifo

module qzs_top
  import qzs_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [NUM_CH-1:0] chanGate,
  input wire logic commonGate,
  output logic [NUM_CH-1:0] integrateEn,
  output logic integratorClear,
  output logic [SEL_W-1:0] muxSel,
  output logic adcStart,
  input wire logic adcDone,
  input wire logic [ADC_W-1:0] adcDataA,
  input wire logic [ADC_W-1:0] adcDataB,
  input wire logic adcOvrA,
  input wire logic adcOvrB,
  output logic [THR_W-1:0] slideOffset,
  input wire qzs_ctrl_t ctrl,
  input wire logic regWrEn,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  output logic busy,
  output logic dataValid,
  input wire logic dataReady,
  output qzs_datum_t dataOut
);

  if (CLEAR_CYC < 1 || CLEAR_CYC > (1 << CLR_W) - 1)
  begin : g_bad_clear
    $error("qzs_top: clear time does not fit its counter");
  end
  if (NUM_CH != 2 * CH_PER_ADC || CH_PER_ADC != MUX_GROUP * MUX_GROUP)
  begin : g_bad_split
    $error("qzs_top: channel split must be 2 x 4 x 4");
  end

  // Decide storage for one result; returns {keep, 16-bit word}
  function automatic logic [16:0] qzs_judge(
    input logic [ADC_W-1:0] raw,
    input logic ovrIn,
    input logic [15:0] thr,
    input qzs_ctrl_t c,
    input logic [THR_W-1:0] slide
  );
    logic [ADC_W:0] diff;
    logic [ADC_W-1:0] val;
    logic ovr;
    logic below;
    logic keep;
    diff = {1'b0, raw} - {5'b0_0000, slide};
    // An underflow after removal can only be noise at the bottom of the scale
    val = c.slideEnable ? (diff[ADC_W] ? '0 : diff[ADC_W-1:0]) : raw;
    ovr = ovrIn | (c.slideEnable & (val > SLIDE_VALID_MAX));
    below = c.fineThreshold
      ? ((val[11:9] == 3'h0) && (val[8:1] < thr[THR_W-1:0]))
      : (val[11:4] < thr[THR_W-1:0]);
    keep = !thr[THR_KILL_BIT]
      && (!ovr || c.keepOverrange)
      && (!below || c.keepBelowThreshold);
    qzs_judge = {keep, 2'b00, below, ovr, val};
  endfunction : qzs_judge

  qzs_state_t state_r;
  qzs_state_t state_nxt;
  logic [SEL_W-1:0] sel_r;
  logic [CLR_W-1:0] clrCnt_r;
  logic [THR_W-1:0] slide_r;
  logic [ADC_W-1:0] rawA_r;
  logic [ADC_W-1:0] rawB_r;
  logic ovrA_r;
  logic ovrB_r;
  logic [15:0] rdData_r;
  logic [15:0] thrMem [NUM_CH];

  // Threshold memory decode
  wire logic thrHit = (regAddr >= THR_BASE) && (regAddr <= THR_LAST);
  wire logic [4:0] thrIdx = regAddr[5:1];

  // No reset on purpose: thresholds survive every reset
  always_ff @(posedge clk_sys)
  begin
    if (regWrEn && thrHit)
      thrMem[thrIdx] <= regWrData;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      rdData_r <= RD_UNMAPPED;
    else
      rdData_r <= thrHit ? thrMem[thrIdx] : RD_UNMAPPED;
  end

  assign regRdData = rdData_r;

  // Per-converter channel and verdict
  wire logic [4:0] chanA = {1'b0, sel_r};
  wire logic [4:0] chanB = {1'b1, sel_r};
  wire logic [16:0] verdictA = qzs_judge(rawA_r, ovrA_r, thrMem[chanA], ctrl, slide_r);
  wire logic [16:0] verdictB = qzs_judge(rawB_r, ovrB_r, thrMem[chanB], ctrl, slide_r);
  wire logic inStoreA = (state_r == ST_STORE_A);
  wire logic inStoreB = (state_r == ST_STORE_B);
  wire logic gateOpen = (state_r == ST_IDLE) || (state_r == ST_INTEG);
  wire logic lastSel = (sel_r == SEL_W'(CH_PER_ADC - 1));

  logic fifoInValid;
  logic fifoInReady;
  qzs_datum_t fifoInData;

  assign fifoInValid = (inStoreA && verdictA[16]) || (inStoreB && verdictB[16]);
  assign fifoInData.chan = inStoreB ? chanB : chanA;
  assign fifoInData.word = inStoreB ? verdictB[15:0] : verdictA[15:0];

  // Integration only while idle or integrating and both gates are active
  assign integrateEn = gateOpen ? (chanGate & {NUM_CH{commonGate}}) : '0;
  assign integratorClear = (state_r == ST_CLEAR);
  assign adcStart = (state_r == ST_START);
  assign muxSel = sel_r;
  assign slideOffset = ctrl.slideEnable ? slide_r : '0;
  assign busy = !gateOpen;

  // A stalled FIFO holds the sequencer in a store state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (commonGate)
          state_nxt = ST_INTEG;
      ST_INTEG:
        if (!commonGate)
          state_nxt = ST_START;
      ST_START:
        state_nxt = ST_WAIT;
      ST_WAIT:
        if (adcDone)
          state_nxt = ST_STORE_A;
      ST_STORE_A:
        if (!verdictA[16] || fifoInReady)
          state_nxt = ST_STORE_B;
      ST_STORE_B:
        if (!verdictB[16] || fifoInReady)
          state_nxt = lastSel ? ST_CLEAR : ST_START;
      ST_CLEAR:
        if (clrCnt_r == '0)
          state_nxt = ST_IDLE;
    endcase
  end

  wire logic stepDone = inStoreB && (state_nxt != ST_STORE_B);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_r <= '0;
      clrCnt_r <= '0;
      slide_r <= '0;
    end
    else
    begin
      if (state_r == ST_INTEG)
        sel_r <= '0;
      else if (stepDone && !lastSel)
        sel_r <= sel_r + SEL_W'(1);
      if (stepDone && lastSel)
        clrCnt_r <= CLR_W'(CLEAR_CYC - 1);
      else if (clrCnt_r != '0)
        clrCnt_r <= clrCnt_r - CLR_W'(1);
      // New offset per event spreads a level over different converter codes
      if (stepDone && lastSel)
        slide_r <= slide_r + THR_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rawA_r <= '0;
      rawB_r <= '0;
      ovrA_r <= 1'b0;
      ovrB_r <= 1'b0;
    end
    else if (state_r == ST_WAIT && adcDone)
    begin
      rawA_r <= adcDataA;
      rawB_r <= adcDataB;
      ovrA_r <= adcOvrA;
      ovrB_r <= adcOvrB;
    end
  end

  qzs_fifo #(
    .WIDTH($bits(qzs_datum_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(dataValid),
    .outReady(dataReady),
    .outData(dataOut)
  );

endmodule : qzs_top

// *** include/qzs_pkg.sv ***
// Shared constants and types for the gated charge digitiser control path.
// Assumes a single 25 MHz system clock and an asynchronous active-low reset.
package qzs_pkg;

  localparam int NUM_CH = 32;
  localparam int CH_PER_ADC = 16;
  localparam int MUX_GROUP = 4;
  localparam int ADC_W = 12;
  localparam int THR_W = 8;
  localparam int SEL_W = 4;

  // Threshold memory: one 16-bit entry per channel, byte addresses
  localparam logic [15:0] THR_BASE = 16'h1080;
  localparam logic [15:0] THR_LAST = 16'h10BF;
  localparam logic [15:0] RD_UNMAPPED = 16'h0000;
  localparam int THR_KILL_BIT = 8;

  // Stored data word layout
  localparam int WORD_OVF_BIT = 12;
  localparam int WORD_UNDER_BIT = 13;

  // Highest trustworthy result with sliding scale on (3840)
  localparam logic [11:0] SLIDE_VALID_MAX = 12'h0F00;

  // Integrator clear time after conversion
  localparam int CLK_NS = 40;
  localparam int CLEAR_NS = 600;
  localparam int CLEAR_CYC = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLR_W = 5;

  typedef struct packed {
    logic keepBelowThreshold;
    logic keepOverrange;
    logic fineThreshold;
    logic slideEnable;
  } qzs_ctrl_t;

  typedef struct packed {
    logic [4:0] chan;
    logic [15:0] word;
  } qzs_datum_t;

  typedef enum {
    ST_IDLE,
    ST_INTEG,
    ST_START,
    ST_WAIT,
    ST_STORE_A,
    ST_STORE_B,
    ST_CLEAR
  } qzs_state_t;

endpackage : qzs_pkg

// *** tb/qzs_adc_model.sv ***
// Converter pair model: level plus sliding offset, answers lat+1 cycles after the start edge.
// Assumes the bench supplies levels; data lines carry junk between answers.
`timescale 1ns/10ps
module qzs_adc_model
  import qzs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic adcStart,
  input wire logic [SEL_W-1:0] muxSel,
  input wire logic [THR_W-1:0] slideOffset,
  input wire logic [ADC_W-1:0] lvl [NUM_CH],
  input wire logic [3:0] lat,
  output logic adcDone = 1'h0,
  output logic [ADC_W-1:0] adcDataA = 12'h000,
  output logic [ADC_W-1:0] adcDataB = 12'h000,
  output logic adcOvrA,
  output logic adcOvrB
);
  logic [12:0] sumA;
  logic [12:0] sumB;
  logic [4:0] cnt = 5'h00;
  assign sumA = 13'(lvl[{1'h0, muxSel}]) + 13'(slideOffset);
  assign sumB = 13'(lvl[{1'h1, muxSel}]) + 13'(slideOffset);
  assign adcOvrA = sumA[12];
  assign adcOvrB = sumB[12];
  // Inverted data outside the answer cycle catches early or late sampling
  always @(posedge clk_sys)
  begin
    cnt <= adcStart ? 5'(lat) + 5'h01 : cnt - 5'(cnt != 5'h00);
    adcDone <= cnt == 5'h01;
    adcDataA <= cnt == 5'h01 ? sumA[11:0] : ~adcDataA;
    adcDataB <= cnt == 5'h01 ? sumB[11:0] : ~adcDataB;
  end
endmodule : qzs_adc_model

// *** tb/qzs_props.sv ***
// Checker: port properties of qzs_top.
// Assumes ctrl is steady while stored words drain.
`timescale 1ns/10ps
module qzs_props
  import qzs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [NUM_CH-1:0] chanGate,
  input wire logic commonGate,
  input wire logic [NUM_CH-1:0] integrateEn,
  input wire logic integratorClear,
  input wire logic adcStart,
  input wire qzs_ctrl_t ctrl,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regRdData,
  input wire logic busy,
  input wire logic dataValid,
  input wire qzs_datum_t dataOut
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  chk_gate_and: assert property (|integrateEn |-> commonGate && !(|(integrateEn & ~chanGate)))
    else $error("integrate without gates");
  chk_busy_quiet: assert property (busy |-> !(|integrateEn))
    else $error("integrate while busy");
  chk_start_pulse: assert property (adcStart |=> !adcStart)
    else $error("start too long");
  chk_clear_late: assert property (integratorClear |-> busy && !adcStart)
    else $error("clear during conversion");
  chk_clear_run: assert property ($rose(integratorClear) |=> integratorClear [*8])
    else $error("clear too short");
  chk_rd_unmap: assert property (regAddr > THR_LAST |=> regRdData == RD_UNMAPPED)
    else $error("unmapped read");
  chk_ovf_keep: assert property (dataValid && dataOut.word[WORD_OVF_BIT] |->
    ctrl.keepOverrange) else $error("overflow kept");
  chk_under_keep: assert property (dataValid && dataOut.word[WORD_UNDER_BIT] |->
    ctrl.keepBelowThreshold) else $error("below kept");
  chk_word_pad: assert property (dataValid |-> dataOut.word[15:14] == 2'h0)
    else $error("pad bits set");
  cover property (dataValid && dataOut.word[WORD_OVF_BIT]);
  cover property (dataValid && dataOut.word[WORD_UNDER_BIT]);
  cover property ($rose(integratorClear));
endmodule : qzs_props
bind qzs_top qzs_props chk_u (.*);

// *** tb/tb.sv ***
// Bench for qzs_top: threshold bus, gating, stored words, reset keeping.
// Assumes qzs_adc_model on the converter side.
`timescale 1ns/10ps
module tb
  import qzs_pkg::*;
;
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  logic [NUM_CH-1:0] chanGate = 32'h0000_0000;
  logic commonGate = 1'h0;
  logic regWrEn = 1'h0;
  logic [15:0] regAddr = 16'h0000;
  logic [15:0] regWrData = 16'h0000;
  logic dataReady = 1'h0;
  qzs_ctrl_t ctrl = 4'h0;
  logic [3:0] lat = 4'h0;
  logic [ADC_W-1:0] lvl [NUM_CH];
  logic [NUM_CH-1:0] integrateEn;
  logic integratorClear, adcStart, adcDone, adcOvrA, adcOvrB, busy, dataValid;
  logic [SEL_W-1:0] muxSel;
  logic [ADC_W-1:0] adcDataA, adcDataB;
  logic [THR_W-1:0] slideOffset;
  logic [15:0] regRdData;
  qzs_datum_t dataOut;
  int fail_count = 0;
  int tests_run = 0;
  qzs_top dut_u (.*);
  qzs_adc_model adc_u (.*);
  initial forever #20 clk_sys = ~clk_sys;
  task automatic test_done;
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  // Odd channels pass everything; 3 sits high, 6 is killed
  function automatic logic [15:0] thrE(int c);
    if (c == 3)
      return 16'h00FF;
    if (c == 6)
      return 16'h0130;
    return c % 2 ? 16'h0000 : 16'(c * 8);
  endfunction : thrE
  function automatic logic [16:0] expw(int ch, qzs_ctrl_t c);
    logic [11:0] v;
    logic [15:0] e;
    logic o;
    logic b;
    v = lvl[ch];
    e = thrE(ch);
    o = c.slideEnable && v > SLIDE_VALID_MAX;
    b = c.fineThreshold ? v[11:9] == 3'h0 && v[8:1] < e[7:0] : v[11:4] < e[7:0];
    return {!e[THR_KILL_BIT] && (!o || c.keepOverrange) && (!b || c.keepBelowThreshold),
      2'h0, b, o, v};
  endfunction : expw
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'h1;
    @(negedge clk_sys);
    regWrEn = 1'h0;
  endtask : wr
  task automatic rd(logic [15:0] a, logic [15:0] e);
    @(negedge clk_sys);
    regAddr = a;
    @(negedge clk_sys);
    cmp("regRdData", 32'(e), 32'(regRdData));
  endtask : rd
  task automatic t_regs;
    for (int c = 0; c < NUM_CH; c++)
      wr(THR_BASE + 16'(2 * c), thrE(c));
    wr(16'h10C0, 16'h00AA);
    for (int c = 0; c < NUM_CH; c++)
      rd(THR_BASE + 16'(2 * c + c % 2), thrE(c));
    rd(16'h10C0, RD_UNMAPPED);
  endtask : t_regs
  task automatic t_keep;
    @(negedge clk_sys);
    arst_n = 1'h0;
    repeat (2) @(negedge clk_sys);
    arst_n = 1'h1;
    rd(THR_BASE + 16'h0006, thrE(3));
    rd(THR_BASE + 16'h000C, thrE(6));
  endtask : t_keep
  // The sink stalls first so the FIFO fills and holds the sequencer back
  task automatic t_event(qzs_ctrl_t c, logic [3:0] l);
    logic [20:0] q[$];
    logic [16:0] w;
    int n;
    int t;
    n = 0;
    t = 0;
    for (int s = 0; s < 2 * CH_PER_ADC; s++)
    begin
      w = expw(16 * (s % 2) + s / 2, c);
      if (w[16])
        q.push_back({5'(16 * (s % 2) + s / 2), w[15:0]});
    end
    @(negedge clk_sys);
    ctrl = c;
    lat = l;
    chanGate = 32'hA5A5_0F0F;
    @(negedge clk_sys);
    cmp("integrateEn", 32'h0000_0000, integrateEn);
    commonGate = 1'h1;
    @(negedge clk_sys);
    cmp("integrateEn", 32'hA5A5_0F0F, integrateEn);
    repeat (2) @(negedge clk_sys);
    commonGate = 1'h0;
    while (t < 4000 && (t < 4 || busy || dataValid))
    begin
      @(negedge clk_sys);
      t++;
      n += integratorClear;
      dataReady = t > 80;
      // A second gate while converting must not reopen integration
      commonGate = t > 10 && t < 14;
      if (t == 12)
        cmp("integrateEn", 32'h0000_0000, integrateEn);
      if (dataValid && dataReady)
        cmp("dataOut", q.size() > 0 ? 32'(q.pop_front()) : 32'hFFFF_FFFF, 32'(dataOut));
    end
    if (t >= 4000)
    begin
      cmp("timeout", 32'h0000_0000, 32'h0000_0001);
      test_done();
    end
    cmp("clearLen", 32'(CLEAR_CYC), 32'(n));
    cmp("wordsLeft", 32'h0000_0000, 32'(q.size()));
  endtask : t_event
  initial
  begin
    for (int c = 0; c < NUM_CH; c++)
      lvl[c] = 12'(c * 125); // Levels step by 125 from zero, every channel is converted
    repeat (5) @(negedge clk_sys);
    arst_n = 1'h1;
    t_regs();
    t_event(4'h0, 4'h0);
    t_event(4'hC, 4'h5);
    t_event(4'hF, 4'h2);
    t_event(4'h1, 4'h0);
    t_keep();
    test_done();
  end
endmodule : tb
